// ==== hw/nand_host_ctrl.sv ====
// Host controller driving a stacked NAND flash through its pins.
// Function
// - Shared eight-bit bus carries command, address, data.
// - Wait 30 us access; bytes 25 ns apart; code polls ready/busy instead and uses 4-clock (100 ns) bus cycles.
// - Program busy about 300 us typical.
// - Erase busy about 3.5 ms typical.
// - Host corrects 4 bits per 528 bytes; this controller has no correction logic.
// - Five address cycles, upper bits low.
// - Identify with 90h then address 00h.
// - Dummy 00h command before status after identify.
`timescale 1ns/1ps
module nand_host_ctrl #(
  parameter int READ_WAIT_CYC = nand_host_pkg::READ_ACCESS_CYC,
  parameter int BUSY_TIMEOUT_CYC = 4 * nand_host_pkg::ERASE_TYP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request port
  input wire logic reqValid,
  output logic reqReady,
  input wire nand_host_pkg::request_t req,
  input wire logic writeProtectReq,
  // Write data stream
  input wire logic [7:0] wrData,
  input wire logic wrValid,
  output logic wrReady,
  // Read data stream
  output logic [7:0] rdData,
  output logic rdValid,
  // Completion
  output logic opDone,
  output logic opTimeout,
  // Device pins
  output nand_host_pkg::pins_t pins,
  output logic [7:0] busOut,
  output logic busOeN,
  input wire logic [7:0] busIn,
  input wire logic readyBusyN
);

  typedef enum logic [7:0] {
    S_IDLE = 8'h01, S_CMD1 = 8'h02, S_ADDR = 8'h04, S_DATA_W = 8'h08,
    S_CMD2 = 8'h10, S_WAIT = 8'h20, S_DATA_R = 8'h40, S_DUMMY = 8'h80
  } state_t;

  state_t state_q, state_d;
  nand_host_pkg::request_t req_q, req_d;
  logic [2:0] addrIdx_q, addrIdx_d;
  logic [15:0] left_q, left_d;
  logic [31:0] waitCnt_q, waitCnt_d;
  logic idMode_q, idMode_d;
  logic [7:0] byte_q, byte_d;
  logic [7:0] rdData_q, rdData_d;
  logic rdValid_q, rdValid_d;
  logic done_q, done_d, tmo_q, tmo_d;
  logic rbMeta_q, rbSync_q;
  logic [7:0] busMeta_q, busSync_q;
  logic start, strobeLow, cycDone, cycBusy_q, cycBusy_d;

  nand_strobe_gen #(.HALF_CYC(nand_host_pkg::STROBE_HALF_CYC)) u_strobe (
    .clk(clk),
    .rst(rst),
    .start(start),
    .strobeLow(strobeLow),
    .done(cycDone)
  );

  // Address byte n of the five-cycle layout; unused upper bits stay low.
  function automatic logic [7:0] addrByte(
    input nand_host_pkg::request_t r, input logic [2:0] n);
    unique case (n)
      3'h0: addrByte = r.col[7:0];
      3'h1: addrByte = {4'h0, r.col[11:8]};
      3'h2: addrByte = r.row[7:0];
      3'h3: addrByte = r.row[15:8];
      default: addrByte = {4'h0, r.row[19:16]};
    endcase
  endfunction : addrByte

  function automatic logic [2:0] addrCount(input nand_host_pkg::op_t op);
    unique case (op)
      nand_host_pkg::OP_READ_ID: addrCount = 3'h1;
      nand_host_pkg::OP_ERASE: addrCount = 3'h3;
      nand_host_pkg::OP_STATUS: addrCount = 3'h0;
      default: addrCount = 3'(nand_host_pkg::ADDR_CYCLES);
    endcase
  endfunction : addrCount

  function automatic logic [7:0] firstCmd(input nand_host_pkg::op_t op);
    unique case (op)
      nand_host_pkg::OP_READ_ID: firstCmd = nand_host_pkg::CMD_READ_ID;
      nand_host_pkg::OP_ERASE: firstCmd = nand_host_pkg::CMD_ERASE_SETUP;
      nand_host_pkg::OP_PROGRAM: firstCmd = nand_host_pkg::CMD_PROG_SETUP;
      nand_host_pkg::OP_STATUS: firstCmd = nand_host_pkg::CMD_STATUS;
      default: firstCmd = nand_host_pkg::CMD_READ_SETUP;
    endcase
  endfunction : firstCmd

  // Pins from outside pass two flops before any logic reads them.
  always_ff @(posedge clk) begin
    rbMeta_q <= readyBusyN;
    rbSync_q <= rbMeta_q;
    busMeta_q <= busIn;
    busSync_q <= busMeta_q;
  end

  always_comb begin
    state_d = state_q;
    req_d = req_q;
    addrIdx_d = addrIdx_q;
    left_d = left_q;
    waitCnt_d = waitCnt_q;
    idMode_d = idMode_q;
    byte_d = byte_q;
    rdData_d = rdData_q;
    rdValid_d = 1'b0;
    done_d = 1'b0;
    tmo_d = 1'b0;
    start = 1'b0;
    reqReady = 1'b0;
    wrReady = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        reqReady = rbSync_q;
        if (reqValid && rbSync_q) begin
          req_d = req;
          left_d = req.count;
          addrIdx_d = 3'h0;
          if (idMode_q && req.op == nand_host_pkg::OP_STATUS) begin
            byte_d = nand_host_pkg::CMD_READ_SETUP;
            state_d = S_DUMMY;
          end else begin
            byte_d = firstCmd(req.op);
            state_d = S_CMD1;
          end
          idMode_d = (req.op == nand_host_pkg::OP_READ_ID);
          start = 1'b1;
        end
      end
      S_DUMMY: if (cycDone) begin
        byte_d = nand_host_pkg::CMD_STATUS;
        state_d = S_CMD1;
        start = 1'b1;
      end
      S_CMD1: if (cycDone) begin
        if (addrCount(req_q.op) != 3'h0) begin
          addrIdx_d = 3'h0;
          byte_d = (req_q.op == nand_host_pkg::OP_READ_ID) ?
            nand_host_pkg::ID_ADDR :
            (req_q.op == nand_host_pkg::OP_ERASE) ?
            addrByte(req_q, 3'h2) : addrByte(req_q, 3'h0);
          state_d = S_ADDR;
          start = 1'b1;
        end else begin
          state_d = S_DATA_R;
          waitCnt_d = 32'h0000_0000;
        end
      end
      S_ADDR: if (cycDone) begin
        if (addrIdx_q + 3'h1 < addrCount(req_q.op)) begin
          addrIdx_d = addrIdx_q + 3'h1;
          byte_d = (req_q.op == nand_host_pkg::OP_ERASE) ?
            addrByte(req_q, addrIdx_q + 3'h3) :
            addrByte(req_q, addrIdx_q + 3'h1);
          start = 1'b1;
        end else if (req_q.op == nand_host_pkg::OP_PROGRAM) begin
          state_d = S_DATA_W;
        end else if (req_q.op == nand_host_pkg::OP_READ_ID) begin
          state_d = S_DATA_R;
          waitCnt_d = 32'h0000_0000;
        end else begin
          byte_d = (req_q.op == nand_host_pkg::OP_READ) ?
            nand_host_pkg::CMD_READ_CONFIRM :
            nand_host_pkg::CMD_ERASE_CONFIRM;
          state_d = S_CMD2;
          start = 1'b1;
        end
      end
      S_DATA_W: begin
        wrReady = (left_q != 16'h0000) && (!cycBusy_q || cycDone);
        if (left_q == 16'h0000) begin
          if (!cycBusy_q || cycDone) begin
            byte_d = nand_host_pkg::CMD_PROG_CONFIRM;
            state_d = S_CMD2;
            start = 1'b1;
          end
        end else if (wrValid && wrReady) begin
          byte_d = wrData;
          left_d = left_q - 16'h0001;
          start = 1'b1;
        end
      end
      S_CMD2: if (cycDone) begin
        state_d = S_WAIT;
        waitCnt_d = 32'h0000_0000;
      end
      S_WAIT: begin
        // Busy shows after a short delay, so sample ready only past it.
        waitCnt_d = waitCnt_q + 32'h0000_0001;
        if (waitCnt_q > 32'h0000_0004 && rbSync_q) begin
          if (req_q.op == nand_host_pkg::OP_READ) begin
            state_d = S_DATA_R;
            waitCnt_d = 32'h0000_0000;
          end else begin
            done_d = 1'b1;
            state_d = S_IDLE;
          end
        end else if (waitCnt_q == 32'(BUSY_TIMEOUT_CYC)) begin
          tmo_d = 1'b1;
          done_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_DATA_R: begin
        if (cycDone) begin
          rdData_d = busSync_q;
          rdValid_d = 1'b1;
          left_d = left_q - 16'h0001;
        end
        if (left_q == 16'h0000 || (cycDone && left_q == 16'h0001)) begin
          done_d = 1'b1;
          state_d = S_IDLE;
        end else if (!cycBusy_q) begin
          start = 1'b1;
        end
      end
      default: state_d = S_IDLE;
    endcase
    cycBusy_d = start || (cycBusy_q && !cycDone);
  end

  // Read strobes sample bus two cycles late; half period covers the sync.
  always_comb begin
    pins.cmdLatch = (state_q == S_CMD1 || state_q == S_CMD2 ||
      state_q == S_DUMMY);
    pins.addrLatch = (state_q == S_ADDR);
    pins.writeStrobeN = !(strobeLow && state_q != S_DATA_R);
    pins.readStrobeN = !(strobeLow && state_q == S_DATA_R);
    pins.chipSelectN = {nand_host_pkg::CHIP_SELECTS{1'b1}};
    if (state_q != S_IDLE)
      pins.chipSelectN[req_q.chip] = 1'b0;
    pins.writeProtectN = !writeProtectReq;
  end

  assign busOut = byte_q;
  assign busOeN = !(state_q inside {S_CMD1, S_CMD2, S_ADDR, S_DATA_W,
    S_DUMMY});
  assign rdData = rdData_q;
  assign rdValid = rdValid_q;
  assign opDone = done_q;
  assign opTimeout = tmo_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      req_q <= '0;
      addrIdx_q <= 3'h0;
      left_q <= 16'h0000;
      waitCnt_q <= 32'h0000_0000;
      idMode_q <= 1'b0;
      byte_q <= 8'h00;
      rdData_q <= 8'h00;
      rdValid_q <= 1'b0;
      done_q <= 1'b0;
      tmo_q <= 1'b0;
      cycBusy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      addrIdx_q <= addrIdx_d;
      left_q <= left_d;
      waitCnt_q <= waitCnt_d;
      idMode_q <= idMode_d;
      byte_q <= byte_d;
      rdData_q <= rdData_d;
      rdValid_q <= rdValid_d;
      done_q <= done_d;
      tmo_q <= tmo_d;
      cycBusy_q <= cycBusy_d;
    end
  end

endmodule : nand_host_ctrl

// ==== hw/nand_host_pkg.sv ====
// Package with constants and types for the NAND flash host pin controller.
package nand_host_pkg;

  // Array organisation.
  localparam int PAGE_DATA_BYTES = 2048;
  localparam int PAGE_SPARE_BYTES = 128;
  localparam int PAGE_TOTAL_BYTES = PAGE_DATA_BYTES + PAGE_SPARE_BYTES;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int BLOCKS_PER_PLANE = 2048;
  localparam int PLANES_PER_DIE = 2;
  localparam int DIES_PER_PACKAGE = 4;
  localparam int CHIP_SELECTS = 2;
  localparam int ECC_CODEWORD_BYTES = 528;
  localparam int ECC_MIN_BITS = 4;

  // Address field layout.
  localparam int COL_BITS = 12;
  localparam int ROW_BITS = 20;
  localparam int ADDR_CYCLES = 5;
  localparam int ID_BYTES = 5;

  // Command codes.
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] ID_ADDR = 8'h00;

  // Timing, in their own units, and the derived 40 MHz cycle counts.
  localparam int CLK_MHZ = 40;
  localparam int CLK_PERIOD_NS = 25;
  localparam int READ_ACCESS_US = 30;
  localparam int BYTE_SPACING_NS = 25;
  localparam int PROG_TYP_US = 300;
  localparam int ERASE_TYP_US_X10 = 35000;
  localparam int READ_ACCESS_CYC = READ_ACCESS_US * CLK_MHZ;
  localparam int BYTE_SPACING_CYC =
    (BYTE_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_TYP_CYC = PROG_TYP_US * CLK_MHZ;
  localparam int ERASE_TYP_CYC = ERASE_TYP_US_X10 * CLK_MHZ / 10;
  localparam int STROBE_HALF_CYC = 2;

  // Host operations.
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_ERASE = 3'h2,
    OP_READ_ID = 3'h3,
    OP_STATUS = 3'h4
  } op_t;

  typedef struct packed {
    op_t op;
    logic chip;
    logic [ROW_BITS-1:0] row;
    logic [COL_BITS-1:0] col;
    logic [15:0] count;
  } request_t;

  // Pin outputs driven by the host toward the device.
  typedef struct packed {
    logic cmdLatch;
    logic addrLatch;
    logic writeStrobeN;
    logic readStrobeN;
    logic [CHIP_SELECTS-1:0] chipSelectN;
    logic writeProtectN;
  } pins_t;

endpackage : nand_host_pkg

// ==== hw/nand_strobe_gen.sv ====
// Strobe timer that paces one bus cycle: low phase, then high phase.
`timescale 1ns/1ps
module nand_strobe_gen #(
  parameter int HALF_CYC = nand_host_pkg::STROBE_HALF_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Cycle request and progress
  input wire logic start,
  output logic strobeLow,
  output logic done
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic busy_q;
  logic busy_d;
  localparam logic [7:0] LAST = 8'(2 * HALF_CYC - 1);
  localparam logic [7:0] HALF = 8'(HALF_CYC);

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    done = 1'b0;
    if (busy_q) begin
      if (cnt_q == LAST) begin
        // A start in the last cycle chains the next cycle with no idle gap.
        busy_d = start;
        cnt_d = 8'h00;
        done = 1'b1;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end else if (start) begin
      busy_d = 1'b1;
      cnt_d = 8'h00;
    end
  end

  // The strobe rises halfway, so data is latched mid-cycle on the rising edge.
  assign strobeLow = busy_q && (cnt_q < HALF);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

endmodule : nand_strobe_gen

// ==== dv/nand_host_ctrl_asserts.sv ====
// Checker on the host controller's handshake and device pin ports.
`timescale 1ns/1ps
module nand_host_ctrl_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Handshake and completion
  input wire logic reqReady,
  input wire logic writeProtectReq,
  input wire logic opDone,
  input wire logic opTimeout,
  // Device pins
  input wire nand_host_pkg::pins_t pins,
  input wire logic [7:0] busOut,
  input wire logic busOeN,
  input wire logic readyBusyN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr_cycle;
    !pins.writeStrobeN ##1 !pins.writeStrobeN ##1 pins.writeStrobeN;
  endsequence
  sequence s_rd_cycle;
    !pins.readStrobeN ##1 !pins.readStrobeN ##1 pins.readStrobeN[*2];
  endsequence
  sequence s_busy;
    !readyBusyN[*4];
  endsequence
  property p_latch_excl;
    !(pins.cmdLatch && pins.addrLatch);
  endproperty
  property p_latch_hold;
    !pins.writeStrobeN && !$past(pins.writeStrobeN) |-> !busOeN &&
      $stable(pins.cmdLatch) && $stable(pins.addrLatch) && $stable(busOut);
  endproperty
  property p_wr_pulse;
    $fell(pins.writeStrobeN) |-> s_wr_cycle;
  endproperty
  property p_rd_pulse;
    $fell(pins.readStrobeN) |-> s_rd_cycle;
  endproperty
  property p_rd_release;
    !pins.readStrobeN |-> busOeN;
  endproperty
  property p_sel_one;
    !pins.writeStrobeN || !pins.readStrobeN |-> $onehot(~pins.chipSelectN);
  endproperty
  property p_idle_pins;
    reqReady |-> pins.chipSelectN == 2'h3 && busOeN &&
      pins.writeStrobeN && pins.readStrobeN;
  endproperty
  property p_busy_refuse;
    s_busy |-> !reqReady;
  endproperty
  property p_timeout_done;
    opTimeout |-> opDone ##1 !opDone;
  endproperty
  property p_wp_pin;
    pins.writeProtectN == !writeProtectReq;
  endproperty
  a_latch_excl: assert property (p_latch_excl)
    else $error("both latch enables high");
  a_latch_hold: assert property (p_latch_hold)
    else $error("bus or latch moved during write strobe");
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe low time wrong");
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read strobe timing wrong");
  a_rd_release: assert property (p_rd_release)
    else $error("host drives bus during read strobe");
  a_sel_one: assert property (p_sel_one)
    else $error("strobe without exactly one select");
  a_idle_pins: assert property (p_idle_pins)
    else $error("pins not idle while ready for request");
  a_busy_refuse: assert property (p_busy_refuse)
    else $error("request accepted while device busy");
  a_timeout_done: assert property (p_timeout_done)
    else $error("timeout without single done pulse");
  a_wp_pin: assert property (p_wp_pin)
    else $error("write protect pin wrong");
endmodule : nand_host_ctrl_asserts
bind nand_host_ctrl nand_host_ctrl_asserts nand_host_ctrl_asserts_inst (
  .clk, .rst, .reqReady, .writeProtectReq, .opDone, .opTimeout, .pins,
  .busOut, .busOeN, .readyBusyN);

// ==== dv/nand_flash_model.sv ====
// Behavioural stacked NAND flash answering the host controller's pins.
`timescale 1ns/1ps
module nand_flash_model #(
  parameter int BUSY_CYC = 60,
  parameter int STALL_CYC = 400,
  // Identification bytes; the value is arbitrary.
  parameter logic [39:0] ID_CODE = 40'h5A_A5_3C_C3_11
) (
  // Clock for busy timing
  input wire logic clk,
  // Pins from the host, and the bench's stall control
  input wire nand_host_pkg::pins_t pins,
  input wire logic [7:0] busOut,
  input wire logic stall,
  // Pins toward the host
  output logic [7:0] busIn,
  output logic readyBusyN
);
  logic [7:0] mem [int];
  logic [7:0] pbuf [$];
  logic [7:0] adr [5];
  logic [7:0] cmd = 8'h00;
  logic [7:0] outByte = 8'h00;
  logic outEn = 1'b0;
  logic failQ = 1'b0;
  logic idMode = 1'b0;
  int busyCnt = 0;
  int ai = 0;
  int off = 0;
  int violations = 0;
  int ks [$];
  wire sel = pins.chipSelectN != 2'h3;
  wire [31:0] base = {adr[4][3:0], adr[3], adr[2], adr[1][3:0], adr[0]};
  // A released bus shows the inverse so stale data is never read as good.
  assign busIn = (outEn && sel) ? outByte : ~outByte;
  assign readyBusyN = busyCnt == 0;
  always @(posedge clk) if (busyCnt > 0) busyCnt = busyCnt - 1;
  always @(posedge pins.writeStrobeN) if (sel) begin
    outEn = 1'b0;
    if (pins.cmdLatch) begin
      if (busyCnt > 0 && busOut != 8'h70) violations++;
      if (busOut == 8'h70 && idMode) violations++;
      cmd = busOut;
      ai = 0;
      idMode = 1'b0;
      if (busOut == 8'h80) pbuf.delete();
      if (busOut == 8'h30 || busOut == 8'h10) begin
        if (adr[1][7:4] != 4'h0 || adr[4][7:4] != 4'h0) violations++;
        busyCnt = BUSY_CYC;
        off = 0;
      end
      if (busOut == 8'h10 || busOut == 8'hD0) begin
        failQ = !pins.writeProtectN;
        busyCnt = stall ? STALL_CYC : BUSY_CYC;
      end
      if (busOut == 8'h10 && pins.writeProtectN) begin
        foreach (pbuf[i])
          if (base[11:0] + i < nand_host_pkg::PAGE_TOTAL_BYTES)
            mem[base + i] = pbuf[i];
      end
      if (busOut == 8'hD0 && pins.writeProtectN) begin
        ks.delete();
        foreach (mem[k])
          if (k[31:18] == {adr[2][3:0], adr[1], adr[0][7:6]}) ks.push_back(k);
        foreach (ks[i]) mem.delete(ks[i]);
      end
    end else if (pins.addrLatch) begin
      if (ai < 5) adr[ai] = busOut;
      ai++;
      if (cmd == 8'h90) idMode = busOut == 8'h00;
      off = 0;
    end else if (cmd == 8'h80) pbuf.push_back(busOut);
  end
  always @(negedge pins.readStrobeN) if (sel) begin
    outEn = 1'b1;
    if (idMode) outByte = ID_CODE[39 - 8 * off -: 8];
    else if (cmd == 8'h70)
      outByte = {pins.writeProtectN, readyBusyN, 5'h00, failQ};
    else outByte = mem.exists(base + off) ? mem[base + off] : 8'hFF;
    off++;
  end
endmodule : nand_flash_model

// ==== dv/nand_host_ctrl_bench.sv ====
// Self-checking bench for the NAND host pin controller.
`timescale 1ns/1ps
module nand_host_ctrl_bench;
  localparam logic [39:0] ID_CODE = 40'h5A_A5_3C_C3_11; // Arbitrary value.
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reqValid;
  logic reqReady;
  nand_host_pkg::request_t req;
  logic writeProtectReq;
  logic [7:0] wrData;
  logic wrValid;
  logic wrReady;
  logic [7:0] rdData;
  logic rdValid;
  logic opDone;
  logic opTimeout;
  nand_host_pkg::pins_t pins;
  logic [7:0] busOut;
  logic busOeN;
  logic [7:0] busIn;
  logic readyBusyN;
  logic stall;
  logic [7:0] expQ [$];
  logic doneQ [$];
  logic [7:0] wq [$];
  logic [7:0] pat [8];
  logic [7:0] seed = 8'h0C;
  logic [19:0] row;
  logic [11:0] col;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  nand_host_ctrl #(.READ_WAIT_CYC(200), .BUSY_TIMEOUT_CYC(200))
    nand_host_ctrl_inst (.clk, .rst, .reqValid, .reqReady, .req,
    .writeProtectReq, .wrData, .wrValid, .wrReady, .rdData, .rdValid,
    .opDone, .opTimeout, .pins, .busOut, .busOeN, .busIn, .readyBusyN);
  nand_flash_model #(.BUSY_CYC(60), .STALL_CYC(400), .ID_CODE(ID_CODE))
    nand_flash_model_inst (.clk, .pins, .busOut, .stall, .busIn,
    .readyBusyN);
  always #12.5 clk = ~clk;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // Requests wait for ready, so a busy device holds the next one back.
  task automatic runOp(input nand_host_pkg::op_t op, input logic chip,
      input int n, input logic wp, input logic tmo);
    int t;
    t = 0;
    doneQ.push_back(tmo);
    req = '{op: op, chip: chip, row: row, col: col, count: 16'(n)};
    writeProtectReq = wp;
    reqValid = 1'b1;
    while (reqReady !== 1'b1 && t < 3000) begin @(posedge clk); #1; t++; end
    @(posedge clk); #1;
    reqValid = 1'b0;
    while (opDone !== 1'b1 && t < 6000) begin @(posedge clk); #1; t++; end
    check(t < 6000, "op hang");
    $display("test op %0d done at %0t", op, $time);
  endtask : runOp
  always @(posedge clk) begin
    if (wrValid && wrReady) void'(wq.pop_front());
    #1;
    wrValid = wq.size() != 0;
    wrData = wrValid ? wq[0] : 8'h00;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      check(1'b0, "timeout");
      conclude();
    end
    if (rdValid === 1'b1)
      check(expQ.size() != 0 && rdData === expQ.pop_front(), "read");
    if (opDone === 1'b1) begin
      check(doneQ.size() != 0, "done count");
      check(opTimeout === doneQ.pop_front(), "timeout flag");
    end
  end
  initial begin
    reqValid = 1'b0;
    req = '0;
    writeProtectReq = 1'b0;
    stall = 1'b0;
    row = 20'h0;
    col = 12'h0;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 5; i++) expQ.push_back(ID_CODE[39 - 8 * i -: 8]);
    runOp(nand_host_pkg::OP_READ_ID, 1'b0, 5, 1'b0, 1'b0);
    expQ.push_back(8'hC0);
    runOp(nand_host_pkg::OP_STATUS, 1'b0, 1, 1'b0, 1'b0);
    foreach (pat[i]) begin seed = lfsr(seed); pat[i] = seed; end
    row = {4'h5, pat[0], pat[1]};
    col = {3'h0, pat[2][0], pat[3]};
    foreach (pat[i]) wq.push_back(pat[i]);
    runOp(nand_host_pkg::OP_PROGRAM, 1'b0, 8, 1'b0, 1'b0);
    foreach (pat[i]) expQ.push_back(pat[i]);
    runOp(nand_host_pkg::OP_READ, 1'b0, 8, 1'b0, 1'b0);
    foreach (pat[i]) wq.push_back(~pat[i]);
    runOp(nand_host_pkg::OP_PROGRAM, 1'b0, 8, 1'b1, 1'b0);
    expQ.push_back(8'hC1);
    runOp(nand_host_pkg::OP_STATUS, 1'b0, 1, 1'b0, 1'b0);
    foreach (pat[i]) expQ.push_back(pat[i]);
    runOp(nand_host_pkg::OP_READ, 1'b0, 8, 1'b0, 1'b0);
    runOp(nand_host_pkg::OP_ERASE, 1'b1, 0, 1'b0, 1'b0);
    repeat (8) expQ.push_back(8'hFF);
    runOp(nand_host_pkg::OP_READ, 1'b1, 8, 1'b0, 1'b0);
    stall = 1'b1;
    wq.push_back(pat[0]);
    runOp(nand_host_pkg::OP_PROGRAM, 1'b0, 1, 1'b0, 1'b1);
    stall = 1'b0;
    expQ.push_back(8'hC0);
    runOp(nand_host_pkg::OP_STATUS, 1'b0, 1, 1'b0, 1'b0);
    repeat (4) @(posedge clk);
    check(expQ.size() == 0 && doneQ.size() == 0, "results missing");
    check(nand_flash_model_inst.violations == 0, "protocol");
    conclude();
  end
endmodule : nand_host_ctrl_bench
